// >>> logic/bayer_stream_pkg.sv
// shared widths and defaults for the bayer stream host controller
`default_nettype none
package bayer_stream_pkg;

	// ----------------------------------------------------------------
	// build-time stream shape
	// ----------------------------------------------------------------
	localparam int unsigned COMP_BITS    = 10;
	localparam int unsigned SAMPLES_CLK  = 2;
	localparam int unsigned colour_channel_count = 3;

	// ----------------------------------------------------------------
	// side-band field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned SOF_USER_BIT = 0;
	localparam logic        TID_VALUE    = 1'h0;
	localparam logic        TDEST_VALUE  = 1'h0;
	localparam logic        RESET_ACTIVE = 1'h0;

	// ----------------------------------------------------------------
	// bus widths rounded up to whole bytes
	// ----------------------------------------------------------------
	function automatic int unsigned byte_round(input int unsigned bits);
		return (bits + 7) / 8 * 8;
	endfunction

endpackage
`default_nettype wire

// >>> logic/bayer_stream_host.sv
// host controller feeding bayer samples to and collecting rgb pixels from the core
//
// Overview of operation
// - source packs samples low, zero fills top
// - input sample 0 in low bits
// - beat moves when ready, valid, reset high
// - only active video samples are streamed
// - source holds stream signals until accepted
// - source never retracts an offered beat
// - source may offer next beat back to back
// - receiver ready may depend on valid
// - receiver ready preferably independent of valid
// - start of frame marks first pixel only
// - start marker may precede valid
// - end of line marks last pixel
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// two-entry register slice: ready and data both leave flip-flops
// ----------------------------------------------------------------
module stream_slice #(
	parameter int unsigned W = 8
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rstn,
	input  wire logic         ce,
	// filling side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// draining side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	logic [W-1:0] spare_reg;
	logic         spare_valid_reg;

	wire in_take   = in_valid && in_ready;
	wire out_free  = out_ready || !out_valid;
	// a spare entry only fills while the main entry is held
	wire spare_valid_next = out_free ? 1'b0 : (spare_valid_reg || in_take);
	wire spare_load = !out_free && in_take;
	wire main_load = out_free && (spare_valid_reg || in_take);
	wire [W-1:0] main_next = spare_valid_reg ? spare_reg : in_data;
	// an offered beat stays up until the far side takes it
	wire valid_next = out_free ? (spare_valid_reg || in_take) : 1'b1;
	// ready is registered, so it only tells whether the spare is free
	wire ready_next = !spare_valid_next;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			out_valid       <= 1'b0;
			in_ready        <= 1'b0;
			spare_valid_reg <= 1'b0;
		end else if (ce) begin
			out_valid       <= valid_next;
			in_ready        <= ready_next;
			spare_valid_reg <= spare_valid_next;
		end
	end

	// data moves only on a load, so an offered word never changes
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			out_data  <= '0;
			spare_reg <= '0;
		end else if (ce) begin
			if (main_load) begin
				out_data <= main_next;
			end
			if (spare_load) begin
				spare_reg <= in_data;
			end
		end
	end
endmodule // stream_slice

// ----------------------------------------------------------------
// top: upstream source and downstream receiver of the core
// ----------------------------------------------------------------
module bayer_stream_host #(
	parameter int unsigned COMP_BITS = bayer_stream_pkg::COMP_BITS,
	parameter int unsigned SAMPLES_CLK = bayer_stream_pkg::SAMPLES_CLK,
	parameter int unsigned CHANNELS = bayer_stream_pkg::colour_channel_count,
	parameter int unsigned IN_W = bayer_stream_pkg::byte_round(COMP_BITS * SAMPLES_CLK),
	parameter int unsigned packed_pixel_bits = COMP_BITS * CHANNELS * SAMPLES_CLK,
	parameter int unsigned OUT_W = bayer_stream_pkg::byte_round(packed_pixel_bits)
) (
	// clock, reset, enable
	input  wire logic                            ref_clk,
	input  wire logic                            rstn,
	input  wire logic                            ce,
	// user sample source
	input  wire logic                            smp_valid,
	output logic                                 smp_ready,
	input  wire logic [COMP_BITS*SAMPLES_CLK-1:0] smp_data,
	input  wire logic                            smp_sof,
	input  wire logic                            smp_eol,
	// user pixel sink
	output logic                                 pix_valid,
	input  wire logic                            pix_ready,
	output logic [packed_pixel_bits-1:0]         pix_data,
	output logic                                 pix_sof,
	output logic                                 pix_eol,
	// protocol error flags, sticky
	input  wire logic                            err_clear,
	output logic                                 err_pad_reg,
	output logic                                 err_sof_reg,
	// core reset driven to the device
	output logic                                 core_reset_low,
	// device input stream
	output logic                                 s_tvalid,
	input  wire logic                            s_tready,
	output logic [IN_W-1:0]                      s_tdata,
	output logic                                 s_tuser,
	output logic                                 s_tlast,
	output logic [IN_W/8-1:0]                    s_tstrb,
	output logic [IN_W/8-1:0]                    s_tkeep,
	output logic                                 s_tid,
	output logic                                 s_tdest,
	// device output stream
	input  wire logic                            m_tvalid,
	output logic                                 m_tready,
	input  wire logic [OUT_W-1:0]                m_tdata,
	input  wire logic                            m_tuser,
	input  wire logic                            m_tlast,
	input  wire logic [OUT_W/8-1:0]              m_tstrb,
	input  wire logic [OUT_W/8-1:0]              m_tkeep,
	input  wire logic                            m_tdest,
	input  wire logic                            interrupt
);
	import bayer_stream_pkg::*;

	localparam int unsigned SMP_BITS = COMP_BITS * SAMPLES_CLK;
	localparam int unsigned TX_W = IN_W + 2;
	localparam int unsigned RX_W = packed_pixel_bits + 2;

	// ce gates only this block while the core runs on: drop it only while
	// neither device port holds an offered beat, else a beat is lost or
	// handed over twice

	// ----------------------------------------------------------------
	// device reset: released one edge after ours, so the core sees it
	// low for at least one rising edge
	// ----------------------------------------------------------------
	// a frozen host never releases the core either
	logic core_reset_low_reg;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			core_reset_low_reg <= RESET_ACTIVE;
		end else if (ce) begin
			core_reset_low_reg <= !RESET_ACTIVE;
		end
	end
	assign core_reset_low = core_reset_low_reg;

	// ----------------------------------------------------------------
	// transmit path: samples sit low, padding above is zero
	// ----------------------------------------------------------------
	wire [IN_W-1:0] tx_bus = IN_W'(smp_data[SMP_BITS-1:0]);
	wire [TX_W-1:0] tx_in  = {smp_sof, smp_eol, tx_bus};
	wire [TX_W-1:0] tx_out;
	// hold back offers while the core is in reset, nothing is lost
	wire tx_drain = s_tready && core_reset_low_reg;

	// the user offers active samples only; blanking never reaches here
	stream_slice #(
		.W(TX_W)
	) tx_slice (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.ce       (ce),
		.in_valid (smp_valid),
		.in_ready (smp_ready),
		.in_data  (tx_in),
		.out_valid(s_tvalid),
		.out_ready(tx_drain),
		.out_data (tx_out)
	);

	// between beats the markers keep the last word; only a taken beat counts
	assign s_tuser = tx_out[TX_W-1];
	assign s_tlast = tx_out[TX_W-2];
	assign s_tdata = tx_out[IN_W-1:0];

	// side-band qualifiers: every byte is a data byte
	// constant, but kept in flops so that every output leaves a register
	logic [IN_W/8-1:0] lane_mask_reg;
	logic              tid_reg;
	logic              tdest_reg;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			lane_mask_reg <= '1;
			tid_reg       <= TID_VALUE;
			tdest_reg     <= TDEST_VALUE;
		end else if (ce) begin
			lane_mask_reg <= '1;
			tid_reg       <= TID_VALUE;
			tdest_reg     <= TDEST_VALUE;
		end
	end
	assign s_tstrb = lane_mask_reg;
	assign s_tkeep = lane_mask_reg;
	assign s_tid   = tid_reg;
	assign s_tdest = tdest_reg;

	// ----------------------------------------------------------------
	// receive path: ready comes from the slice, independent of valid
	// ----------------------------------------------------------------
	wire rx_offer = m_tvalid && core_reset_low_reg;
	wire rx_take  = rx_offer && m_tready;
	// pad bits stop here; they are only checked below
	wire [packed_pixel_bits-1:0] rx_pixels = m_tdata[packed_pixel_bits-1:0];
	wire [RX_W-1:0] rx_in = {m_tuser, m_tlast, rx_pixels};
	wire [RX_W-1:0] rx_out;

	stream_slice #(
		.W(RX_W)
	) rx_slice (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.ce       (ce),
		.in_valid (rx_offer),
		.in_ready (m_tready),
		.in_data  (rx_in),
		.out_valid(pix_valid),
		.out_ready(pix_ready),
		.out_data (rx_out)
	);

	assign pix_sof  = rx_out[RX_W-1];
	assign pix_eol  = rx_out[RX_W-2];
	assign pix_data = rx_out[packed_pixel_bits-1:0];

	// ----------------------------------------------------------------
	// protocol checks on accepted beats
	// ----------------------------------------------------------------
	wire pad_bad;
	generate
		if (OUT_W > packed_pixel_bits) begin : g_pad
			assign pad_bad = |m_tdata[OUT_W-1:packed_pixel_bits];
		end else begin : g_nopad
			assign pad_bad = 1'b0;
		end
	endgenerate

	// ----------------------------------------------------------------
	// line position and sticky error flags
	// ----------------------------------------------------------------
	// start of frame is legal only on the first beat of a line
	logic line_start_reg;
	wire  sof_bad = m_tuser && !line_start_reg;
	// a core held in reset forgets its line position, so we do too
	wire  line_start_next = !core_reset_low_reg ? 1'b1 :
		(rx_take ? m_tlast : line_start_reg);
	// a fresh error wins over a clear in the same cycle
	wire  pad_event    = rx_take && pad_bad;
	wire  sof_event    = rx_take && sof_bad;
	wire  err_pad_next = pad_event || (err_pad_reg && !err_clear);
	wire  err_sof_next = sof_event || (err_sof_reg && !err_clear);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			line_start_reg <= 1'b1;
		end else if (ce) begin
			line_start_reg <= line_start_next;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			err_pad_reg <= 1'b0;
			err_sof_reg <= 1'b0;
		end else if (ce) begin
			err_pad_reg <= err_pad_next;
			err_sof_reg <= err_sof_next;
		end
	end

	// strobes, keep, dest and the reserved interrupt carry nothing we use;
	// the reduction only marks them as left unused on purpose
	wire unused_inputs = ^{m_tstrb, m_tkeep, m_tdest, interrupt};

endmodule // bayer_stream_host
`default_nettype wire

// >>> verification/stream_host_asserts.sv
// concurrent checks on the ports of the bayer stream host
`timescale 1ns/1ps
`default_nettype none
module stream_host_asserts #(
	parameter int SW = 20, PW = 60, IN_W = 24, OUT_W = 64
) (
	input wire logic ref_clk, rstn, ce, err_pad_reg, core_reset_low,
	input wire logic smp_valid, smp_ready, smp_sof, smp_eol,
	input wire logic [SW-1:0] smp_data,
	input wire logic pix_valid, pix_ready, pix_sof, pix_eol,
	input wire logic [PW-1:0] pix_data,
	input wire logic s_tvalid, s_tready, s_tuser, s_tlast, s_tid, s_tdest,
	input wire logic [IN_W-1:0] s_tdata,
	input wire logic [IN_W/8-1:0] s_tstrb, s_tkeep,
	input wire logic m_tvalid, m_tready, m_tuser, m_tlast,
	input wire logic [OUT_W-1:0] m_tdata
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	wire s_take = smp_valid && smp_ready && ce;
	wire m_take = m_tvalid && m_tready && core_reset_low && ce;
	a_reset_quiet: assert property (!core_reset_low |-> !s_tvalid && !m_tready && !smp_ready)
		else $error("stream active while core held in reset");
	a_src_hold: assert property (s_tvalid && !(s_tready && core_reset_low) |=> s_tvalid
		&& $stable(s_tdata) && $stable(s_tuser) && $stable(s_tlast)) else $error("offered beat moved");
	a_pad_zero: assert property (s_tvalid |-> s_tdata[IN_W-1:SW] == '0)
		else $error("input pad bits not zero");
	a_side_fixed: assert property (s_tstrb == '1 && s_tkeep == '1 && !s_tid && !s_tdest)
		else $error("side-band qualifiers wrong");
	a_sample_path: assert property (s_take && !s_tvalid |=> s_tvalid && s_tdata[SW-1:0] ==
		$past(smp_data) && s_tuser == $past(smp_sof) && s_tlast == $past(smp_eol))
		else $error("sample beat not forwarded");
	a_pix_path: assert property (m_take && !pix_valid |=> pix_valid && pix_data ==
		$past(m_tdata[PW-1:0]) && pix_sof == $past(m_tuser) && pix_eol == $past(m_tlast))
		else $error("pixel beat not forwarded");
	a_pix_hold: assert property (pix_valid && !pix_ready |=> pix_valid && $stable(pix_data))
		else $error("pixel beat dropped");
	a_pad_flag: assert property (m_take && m_tdata[OUT_W-1:PW] != '0 |=> err_pad_reg)
		else $error("nonzero pad not flagged");
	c_line_end: cover property (m_take && m_tlast);
	c_stall: cover property (s_tvalid && !s_tready);
	c_pad: cover property (err_pad_reg);
endmodule // stream_host_asserts
bind bayer_stream_host stream_host_asserts #(.SW(COMP_BITS * SAMPLES_CLK), .PW(packed_pixel_bits),
	.IN_W(IN_W), .OUT_W(OUT_W)) u_chk (.ref_clk, .rstn, .ce, .err_pad_reg, .core_reset_low,
	.smp_valid, .smp_ready, .smp_sof, .smp_eol, .smp_data, .pix_valid, .pix_ready, .pix_sof,
	.pix_eol, .pix_data, .s_tvalid, .s_tready, .s_tuser, .s_tlast, .s_tid, .s_tdest, .s_tdata,
	.s_tstrb, .s_tkeep, .m_tvalid, .m_tready, .m_tuser, .m_tlast, .m_tdata);
`default_nettype wire

// >>> verification/bayer_core_model.sv
// behavioural model of the interpolation core on the far side of the host
`timescale 1ns/1ps
`default_nettype none
module bayer_core_model (
	input wire logic ref_clk, core_reset_low, slow, bad_pad,
	input wire logic s_tvalid, s_tuser, s_tlast,
	input wire logic [23:0] s_tdata,
	output logic s_tready,
	input wire logic m_tready,
	output logic m_tvalid, m_tuser, m_tlast, interrupt,
	output logic [63:0] m_tdata
);
	logic stall_reg;
	function automatic logic [29:0] px(input logic [9:0] s);
		return {s + 10'h001, s ^ 10'h3ff, s};
	endfunction
	wire take = s_tvalid && s_tready;
	assign interrupt = 1'b0;
	// one output entry only, so input waits whenever it cannot drain
	assign s_tready = core_reset_low && !stall_reg && (!m_tvalid || m_tready);
	always_ff @(posedge ref_clk) begin
		if (!core_reset_low) begin
			m_tvalid <= 1'b0;
			m_tuser <= 1'b0;
			m_tlast <= 1'b0;
			stall_reg <= 1'b0;
		end else begin
			// flush after a line end; slow mode adds a stall every other cycle
			stall_reg <= (take && s_tlast) || (slow && !stall_reg);
			if (take) begin
				m_tvalid <= 1'b1;
				m_tdata <= {bad_pad ? 4'hf : 4'h0, px(s_tdata[19:10]), px(s_tdata[9:0])};
				m_tuser <= s_tuser;
				m_tlast <= s_tlast;
			end else if (m_tvalid && m_tready) begin
				m_tvalid <= 1'b0;
				m_tdata <= ~m_tdata;
			end
		end
	end
endmodule // bayer_core_model
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench: bayer stream host against a behavioural core
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic ref_clk, rstn, ce, smp_valid, smp_sof, smp_eol, pix_ready, err_clear, slow, bad_pad;
	logic smp_ready, pix_valid, pix_sof, pix_eol, err_pad_reg, err_sof_reg, core_reset_low;
	logic s_tvalid, s_tready, s_tuser, s_tlast, s_tid, s_tdest;
	logic m_tvalid, m_tready, m_tuser, m_tlast, interrupt;
	logic [19:0] smp_data;
	logic [59:0] pix_data;
	logic [23:0] s_tdata;
	logic [2:0] s_tstrb, s_tkeep;
	logic [63:0] m_tdata;
	int error_cnt, checked, cyc;
	bayer_stream_host dut (.ref_clk, .rstn, .ce, .smp_valid, .smp_ready, .smp_data, .smp_sof,
		.smp_eol, .pix_valid, .pix_ready, .pix_data, .pix_sof, .pix_eol, .err_clear, .err_pad_reg,
		.err_sof_reg, .core_reset_low, .s_tvalid, .s_tready, .s_tdata, .s_tuser, .s_tlast, .s_tstrb,
		.s_tkeep, .s_tid, .s_tdest, .m_tvalid, .m_tready, .m_tdata, .m_tuser, .m_tlast,
		.m_tstrb(8'hff), .m_tkeep(8'hff), .m_tdest(1'b0), .interrupt);
	bayer_core_model core (.ref_clk, .core_reset_low, .slow, .bad_pad, .s_tvalid, .s_tuser,
		.s_tlast, .s_tdata, .s_tready, .m_tready, .m_tvalid, .m_tuser, .m_tlast, .interrupt, .m_tdata);
	function automatic logic [29:0] rgb(input logic [9:0] s);
		return {s + 10'h001, s ^ 10'h3ff, s};
	endfunction
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// with freeze set, ce stays low over the release and nothing may move
	task automatic t_reset(input logic freeze);
		rstn = 1'b0;
		repeat (3) @(negedge ref_clk);
		check({core_reset_low, s_tvalid, m_tready, smp_ready, pix_valid}, 5'h00);
		check({s_tstrb, s_tkeep, s_tid, s_tdest}, 8'hfc);
		rstn = 1'b1;
		ce = !freeze;
		@(negedge ref_clk);
		check({core_reset_low, smp_ready, m_tready}, freeze ? 3'h0 : 3'h7);
		ce = 1'b1;
		@(negedge ref_clk);
		check({core_reset_low, smp_ready, m_tready}, 3'h7);
		$display("reset test done");
	endtask
	// source and sink run together so back-pressure from both sides overlaps
	task automatic t_line(input int n, input logic stall, input int sof_at, input logic pad);
		int k, t;
		slow = stall;
		bad_pad = pad;
		k = 0;
		t = 0;
		fork
			begin
				for (int i = 0; i < n; i++) begin
					smp_data = {10'(2 * i + 11), 10'(2 * i + 10)};
					smp_sof = (i == sof_at);
					smp_eol = (i == n - 1);
					smp_valid = 1'b1;
					while (!smp_ready) @(negedge ref_clk);
					@(negedge ref_clk);
				end
				smp_valid = 1'b0;
			end
			while (k < n && t < 200) begin
				@(negedge ref_clk);
				t++;
				pix_ready = stall ? !pix_ready : 1'b1;
				if (pix_valid && pix_ready) begin
					check(pix_data, {rgb(10'(2 * k + 11)), rgb(10'(2 * k + 10))});
					check({pix_sof, pix_eol}, {k == sof_at, k == n - 1});
					k++;
				end
			end
		join
		@(negedge ref_clk);
		check(k, n);
		check({err_pad_reg, err_sof_reg}, {pad, sof_at != 0});
		err_clear = 1'b1;
		@(negedge ref_clk);
		err_clear = 1'b0;
		check({err_pad_reg, err_sof_reg}, 2'h0);
		$display("line test of %0d beats done", n);
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			summarize();
		end
	end
	initial begin
		{rstn, ce, smp_valid, smp_sof, smp_eol, err_clear, slow, bad_pad} = 8'h40;
		smp_data = 20'h0_0000;
		pix_ready = 1'b1;
		t_reset(1'b0);
		t_line(4, 1'b0, 0, 1'b0);
		t_line(6, 1'b1, 0, 1'b0);
		t_line(2, 1'b0, 1, 1'b1);
		t_reset(1'b1);
		t_line(1, 1'b1, 0, 1'b0);
		summarize();
	end
endmodule // tb
`default_nettype wire
